//--- design/cfg_access_defines.vh
`ifndef CFG_ACCESS_DEFINES_VH
`define CFG_ACCESS_DEFINES_VH

// ----------------------------------------------------------------
// token codes
// ----------------------------------------------------------------
`define TOK_WRITE      8'hC0
`define TOK_READ       8'hC1
`define TOK_END        8'h01
`define TOK_ACK        8'h03
`define TOK_NACK       8'h04

// ----------------------------------------------------------------
// field layout
// ----------------------------------------------------------------
`define REPLY_BYTES    2'h2
`define REGNUM_BYTES   2'h1
`define DATA_BYTES     2'h3
`define NOREPLY_LOW    8'hFF
`define PS_RES_TAG     8'h0C
`define PS_REG_LSB     8
`define PS_REG_MSB     23

// ----------------------------------------------------------------
// register file
// ----------------------------------------------------------------
`define NREG           16'h0008
`define REG_AW         3
`define REG_RESET      32'h00000000

// ----------------------------------------------------------------
// reply sequence positions
// ----------------------------------------------------------------
`define TX_LAST_LONG   3'h5
`define TX_LAST_SHORT  3'h1

`endif

//--- design/cfg_msg_endpoint.v
`timescale 1ns/1ps
`include "cfg_access_defines.vh"


module cfg_msg_endpoint (
   input  wire        i_clk,      // system clock, 200 MHz
   input  wire        i_rst,      // sync reset, active high
   input  wire        i_rx_valid, // incoming token valid
   input  wire        i_rx_ctrl,  // incoming token is a control token
   input  wire [7:0]  i_rx_data,  // incoming token value
   output wire        o_rx_ready, // endpoint takes a token
   output wire        o_tx_valid, // outgoing token valid
   output wire        o_tx_ctrl,  // outgoing token is a control token
   output wire [7:0]  o_tx_data,  // outgoing token value
   output wire        o_tx_last,  // last token of the reply
   output wire [23:0] o_tx_dest,  // reply channel-end destination
   input  wire        i_tx_ready, // interconnect takes a token
   input  wire        i_ps_valid, // status access request
   input  wire        i_ps_write, // 1 write, 0 read
   input  wire [31:0] i_ps_resid, // resource identifier
   input  wire [31:0] i_ps_wdata, // status write word
   output wire        o_ps_ready, // status access taken
   output wire        o_ps_ack,   // status access done, pulse
   output wire        o_ps_err,   // status access refused
   output wire [31:0] o_ps_rdata  // status read word
);
   // ----------------------------------------------------------------
   // states
   // ----------------------------------------------------------------
   localparam [6:0] ST_IDLE = 7'h01;
   localparam [6:0] ST_HDR  = 7'h02;
   localparam [6:0] ST_REGN = 7'h04;
   localparam [6:0] ST_DATA = 7'h08;
   localparam [6:0] ST_EOM  = 7'h10;
   localparam [6:0] ST_SKIP = 7'h20;
   localparam [6:0] ST_RESP = 7'h40;

   reg  [6:0]  state_q,   state_d;
   reg  [1:0]  cnt_q,     cnt_d;
   reg  [23:0] reply_q,   reply_d;
   reg  [15:0] regnum_q,  regnum_d;
   reg  [31:0] wdata_q,   wdata_d;
   reg         is_wr_q,   is_wr_d;
   reg         hdr_ok_q,  hdr_ok_d;
   reg         ok_q,      ok_d;
   reg         rd_ok_q,   rd_ok_d;
   reg  [31:0] rdata_q,   rdata_d;
   reg         commit;
   reg  [2:0]  tx_idx_q;
   reg         tx_valid_q;
   reg         tx_ctrl_q;
   reg  [7:0]  tx_data_q;
   reg         tx_last_q;
   reg         ps_ack_q;
   reg         ps_err_q;
   reg  [31:0] ps_rdata_q;
   reg         tok_ctrl;
   reg  [7:0]  tok_data;
   wire        tok_last;
   wire        rx_fire;
   wire        tx_fire;
   wire        is_end;
   wire        reg_ok;
   wire        noreply;
   wire [31:0] rd_a;
   wire [31:0] rd_b;
   wire [15:0] ps_reg;
   wire        ps_ok;
   wire        ps_fire;

   assign o_rx_ready = (state_q != ST_RESP);
   assign rx_fire    = i_rx_valid & o_rx_ready;
   assign tx_fire    = tx_valid_q & i_tx_ready;
   assign is_end     = i_rx_ctrl & (i_rx_data == `TOK_END);
   assign reg_ok     = (regnum_q < `NREG);
   assign noreply    = is_wr_q & (reply_q[7:0] == `NOREPLY_LOW);

   // ----------------------------------------------------------------
   // request parser
   // ----------------------------------------------------------------
   // anything broken before the reply id is complete has nowhere to
   // answer to, so it is dropped silently
   always @* begin
      state_d  = state_q;
      cnt_d    = cnt_q;
      reply_d  = reply_q;
      regnum_d = regnum_q;
      wdata_d  = wdata_q;
      is_wr_d  = is_wr_q;
      hdr_ok_d = hdr_ok_q;
      ok_d     = ok_q;
      rd_ok_d  = rd_ok_q;
      rdata_d  = rdata_q;
      commit   = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (rx_fire) begin
               cnt_d    = 2'h0;
               hdr_ok_d = 1'b0;
               if (i_rx_ctrl && (i_rx_data == `TOK_WRITE)) begin
                  is_wr_d = 1'b1;
                  state_d = ST_HDR;
               end else if (i_rx_ctrl && (i_rx_data == `TOK_READ)) begin
                  is_wr_d = 1'b0;
                  state_d = ST_HDR;
               end else if (!is_end) begin
                  state_d = ST_SKIP;
               end
            end
         end
         ST_HDR: begin
            if (rx_fire) begin
               if (!i_rx_ctrl) begin
                  reply_d = {reply_q[15:0], i_rx_data};
                  cnt_d   = cnt_q + 2'h1;
                  if (cnt_q == `REPLY_BYTES) begin
                     cnt_d    = 2'h0;
                     hdr_ok_d = 1'b1;
                     state_d  = ST_REGN;
                  end
               end else begin
                  state_d = is_end ? ST_IDLE : ST_SKIP;
               end
            end
         end
         ST_REGN: begin
            if (rx_fire) begin
               if (!i_rx_ctrl) begin
                  regnum_d = {regnum_q[7:0], i_rx_data};
                  cnt_d    = cnt_q + 2'h1;
                  if (cnt_q == `REGNUM_BYTES) begin
                     cnt_d   = 2'h0;
                     state_d = is_wr_q ? ST_DATA : ST_EOM;
                  end
               end else begin
                  ok_d    = 1'b0;
                  rd_ok_d = 1'b0;
                  state_d = is_end ? (noreply ? ST_IDLE : ST_RESP) : ST_SKIP;
               end
            end
         end
         ST_DATA: begin
            if (rx_fire) begin
               if (!i_rx_ctrl) begin
                  wdata_d = {wdata_q[23:0], i_rx_data};
                  cnt_d   = cnt_q + 2'h1;
                  if (cnt_q == `DATA_BYTES) begin
                     cnt_d   = 2'h0;
                     state_d = ST_EOM;
                  end
               end else begin
                  ok_d    = 1'b0;
                  rd_ok_d = 1'b0;
                  state_d = is_end ? (noreply ? ST_IDLE : ST_RESP) : ST_SKIP;
               end
            end
         end
         ST_EOM: begin
            if (rx_fire) begin
               if (is_end) begin
                  ok_d    = reg_ok;
                  rd_ok_d = reg_ok & ~is_wr_q;
                  rdata_d = rd_a;
                  commit  = reg_ok & is_wr_q;
                  state_d = noreply ? ST_IDLE : ST_RESP;
               end else begin
                  state_d = ST_SKIP;
               end
            end
         end
         ST_SKIP: begin
            if (rx_fire && is_end) begin
               ok_d    = 1'b0;
               rd_ok_d = 1'b0;
               state_d = (hdr_ok_q && !noreply) ? ST_RESP : ST_IDLE;
            end
         end
         ST_RESP: begin
            if (tx_fire && tx_last_q) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // reply token selection
   // ----------------------------------------------------------------
   assign tok_last = (tx_idx_q == (rd_ok_q ? `TX_LAST_LONG : `TX_LAST_SHORT));

   always @* begin
      tok_ctrl = 1'b1;
      tok_data = `TOK_END;
      if (tx_idx_q == 3'h0) begin
         tok_data = ok_q ? `TOK_ACK : `TOK_NACK;
      end else if (rd_ok_q && !tok_last) begin
         tok_ctrl = 1'b0;
         case (tx_idx_q)
            3'h1:    tok_data = rdata_q[31:24];
            3'h2:    tok_data = rdata_q[23:16];
            3'h3:    tok_data = rdata_q[15:8];
            default: tok_data = rdata_q[7:0];
         endcase
      end
   end

   // ----------------------------------------------------------------
   // processor status access
   // ----------------------------------------------------------------
   // a message commit owns the write port that cycle, so the
   // processor is stalled rather than silently losing its write
   assign ps_reg     = i_ps_resid[`PS_REG_MSB:`PS_REG_LSB];
   assign ps_ok      = (i_ps_resid[7:0] == `PS_RES_TAG) & (ps_reg < `NREG);
   assign o_ps_ready = ~commit;
   assign ps_fire    = i_ps_valid & o_ps_ready;

   cfg_regfile u_regs (
      .i_clk    (i_clk),
      .i_rst    (i_rst),
      .i_we_a   (commit),
      .i_addr_a (regnum_q[`REG_AW-1:0]),
      .i_wd_a   (wdata_q),
      .o_rd_a   (rd_a),
      .i_we_b   (ps_fire & i_ps_write & ps_ok),
      .i_addr_b (ps_reg[`REG_AW-1:0]),
      .i_wd_b   (i_ps_wdata),
      .o_rd_b   (rd_b)
   );

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always @(posedge i_clk) begin
      if (i_rst) begin
         state_q    <= ST_IDLE;
         cnt_q      <= 2'h0;
         reply_q    <= 24'h000000;
         regnum_q   <= 16'h0000;
         wdata_q    <= 32'h00000000;
         is_wr_q    <= 1'b0;
         hdr_ok_q   <= 1'b0;
         ok_q       <= 1'b0;
         rd_ok_q    <= 1'b0;
         rdata_q    <= 32'h00000000;
         tx_idx_q   <= 3'h0;
         tx_valid_q <= 1'b0;
         tx_ctrl_q  <= 1'b0;
         tx_data_q  <= 8'h00;
         tx_last_q  <= 1'b0;
         ps_ack_q   <= 1'b0;
         ps_err_q   <= 1'b0;
         ps_rdata_q <= 32'h00000000;
      end else begin
         state_q  <= state_d;
         cnt_q    <= cnt_d;
         reply_q  <= reply_d;
         regnum_q <= regnum_d;
         wdata_q  <= wdata_d;
         is_wr_q  <= is_wr_d;
         hdr_ok_q <= hdr_ok_d;
         ok_q     <= ok_d;
         rd_ok_q  <= rd_ok_d;
         rdata_q  <= rdata_d;
         if (state_q != ST_RESP) begin
            tx_idx_q <= 3'h0;
         end else if (!tx_valid_q || (tx_fire && !tx_last_q)) begin
            tx_valid_q <= 1'b1;
            tx_ctrl_q  <= tok_ctrl;
            tx_data_q  <= tok_data;
            tx_last_q  <= tok_last;
            tx_idx_q   <= tx_idx_q + 3'h1;
         end else if (tx_fire) begin
            tx_valid_q <= 1'b0;
            tx_last_q  <= 1'b0;
         end
         ps_ack_q <= ps_fire;
         if (ps_fire) begin
            ps_err_q   <= ~ps_ok;
            ps_rdata_q <= (ps_ok && !i_ps_write) ? rd_b : 32'h00000000;
         end
      end
   end

   assign o_tx_valid = tx_valid_q;
   assign o_tx_ctrl  = tx_ctrl_q;
   assign o_tx_data  = tx_data_q;
   assign o_tx_last  = tx_last_q;
   assign o_tx_dest  = reply_q;
   assign o_ps_ack   = ps_ack_q;
   assign o_ps_err   = ps_err_q;
   assign o_ps_rdata = ps_rdata_q;
endmodule // cfg_msg_endpoint

//--- design/cfg_regfile.v
`timescale 1ns/1ps
`include "cfg_access_defines.vh"

module cfg_regfile (
   input  wire        i_clk,    // system clock
   input  wire        i_rst,    // sync reset, active high
   input  wire        i_we_a,   // message-side write
   input  wire [2:0]  i_addr_a, // message-side address
   input  wire [31:0] i_wd_a,   // message-side write data
   output wire [31:0] o_rd_a,   // message-side read data
   input  wire        i_we_b,   // processor-side write
   input  wire [2:0]  i_addr_b, // processor-side address
   input  wire [31:0] i_wd_b,   // processor-side write data
   output wire [31:0] o_rd_b    // processor-side read data
);
   reg [31:0] mem_q [0:7];
   integer    i;

   // port a wins a same-cycle clash; the caller stalls port b anyway
   always @(posedge i_clk) begin
      if (i_rst) begin
         for (i = 0; i < 8; i = i + 1) begin
            mem_q[i] <= `REG_RESET;
         end
      end else if (i_we_a) begin
         mem_q[i_addr_a] <= i_wd_a;
      end else if (i_we_b) begin
         mem_q[i_addr_b] <= i_wd_b;
      end
   end

   assign o_rd_a = mem_q[i_addr_a];
   assign o_rd_b = mem_q[i_addr_b];
endmodule // cfg_regfile

//--- verification/cfg_msg_endpoint_assertions.sv
`timescale 1ns/1ps
`include "cfg_access_defines.vh"

module cfg_msg_endpoint_assertions (
   input wire        i_clk,      // clock
   input wire        i_rst,      // reset
   input wire        o_rx_ready, // token taken
   input wire        o_tx_valid, // reply valid
   input wire        o_tx_ctrl,  // reply control
   input wire [7:0]  o_tx_data,  // reply value
   input wire        o_tx_last,  // reply last
   input wire [23:0] o_tx_dest,  // reply dest
   input wire        i_tx_ready, // sink ready
   input wire        i_ps_valid, // status request
   input wire        i_ps_write, // status write
   input wire [31:0] i_ps_resid, // resource id
   input wire        o_ps_ready, // status taken
   input wire        o_ps_ack,   // status done
   input wire        o_ps_err,   // status refused
   input wire [31:0] o_ps_rdata  // status word
);
   // ----------------------------------------------------------------
   // port relations
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   wire ps_take = i_ps_valid && o_ps_ready;
   wire tag_ok  = i_ps_resid[7:0] == `PS_RES_TAG;

   property p_ack; ps_take |=> o_ps_ack; endproperty
   a_ack: assert property (p_ack) else $error("status ack missing");
   property p_no_ack; !ps_take |=> !o_ps_ack; endproperty
   a_no_ack: assert property (p_no_ack) else $error("status ack unasked");
   property p_tag; ps_take && !tag_ok |=> o_ps_err; endproperty
   a_tag: assert property (p_tag) else $error("bad tag accepted");
   property p_good; ps_take && tag_ok && i_ps_resid[23:8] < `NREG |=> !o_ps_err; endproperty
   a_good: assert property (p_good) else $error("good id refused");
   property p_wr_rd0; ps_take && i_ps_write |=> o_ps_rdata == 32'h00000000; endproperty
   a_wr_rd0: assert property (p_wr_rd0) else $error("write returned data");
   // a stalled sink must see the same token again, never a skipped byte
   property p_hold;
      o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data) && $stable(o_tx_ctrl);
   endproperty
   a_hold: assert property (p_hold) else $error("reply token changed while stalled");
   property p_dest; o_tx_valid && !(i_tx_ready && o_tx_last) |=> $stable(o_tx_dest); endproperty
   a_dest: assert property (p_dest) else $error("reply dest moved");
   property p_last; o_tx_valid && o_tx_last |-> o_tx_ctrl && o_tx_data == `TOK_END; endproperty
   a_last: assert property (p_last) else $error("last token not end");
   // an end token anywhere but last would let the sink close the reply early
   property p_end_last;
      o_tx_valid && o_tx_ctrl && o_tx_data == `TOK_END |-> o_tx_last;
   endproperty
   a_end_last: assert property (p_end_last) else $error("end token not last");
   property p_first;
      $rose(o_tx_valid) |-> o_tx_ctrl && (o_tx_data == `TOK_ACK || o_tx_data == `TOK_NACK);
   endproperty
   a_first: assert property (p_first) else $error("reply opens wrongly");
   property p_busy; o_tx_valid |-> !o_rx_ready; endproperty
   a_busy: assert property (p_busy) else $error("takes tokens while replying");
endmodule // cfg_msg_endpoint_assertions

//--- verification/req_model.sv
`timescale 1ns/1ps

module req_model (
   input  wire        i_clk,             // clock
   input  wire        i_slow,            // stall every other cycle
   input  wire        i_rx_ready,        // endpoint takes token
   input  wire        i_tx_valid,        // reply valid
   input  wire        i_tx_ctrl,         // reply control
   input  wire [7:0]  i_tx_data,         // reply value
   input  wire [23:0] i_tx_dest,         // reply dest
   output reg         o_valid = 1'b0,    // token valid
   output reg         o_ctrl = 1'b0,     // token control
   output reg  [7:0]  o_data = 8'h00,    // token value
   output reg         o_tx_ready = 1'b1  // sink ready
);
   // ----------------------------------------------------------------
   // requesting channel-end
   // ----------------------------------------------------------------
   reg [8:0]  got[$];
   reg [23:0] dest_seen = 24'h000000;

   always @(posedge i_clk) begin
      if (i_tx_valid && o_tx_ready) begin
         got.push_back({i_tx_ctrl, i_tx_data});
         dest_seen <= i_tx_dest;
      end
      o_tx_ready <= !i_slow || !o_tx_ready;
   end

   // valid stays up between tokens so no signal is assigned twice per step
   task put(input c, input [7:0] d);
      o_valid <= 1'b1;
      o_ctrl  <= c;
      o_data  <= d;
      do @(negedge i_clk); while (!i_rx_ready);
      @(posedge i_clk);
   endtask

   // traffic arrives already aimed at the configuration endpoint
   // nb bytes of {id, reg, data}, most significant first; short nb makes a malformed message
   task msg(input [7:0] op, input [23:0] id, input [15:0] rg, input [31:0] wd, input integer nb);
      reg [71:0] b;
      integer    i;
      b = {id, rg, wd};
      put(1'b1, op);
      for (i = 0; i < nb; i = i + 1) put(1'b0, b[71 - 8 * i -: 8]);
      put(1'b1, 8'h01);
      o_valid <= 1'b0;
      o_data  <= ~o_data;
   endtask
endmodule // req_model

//--- verification/testbench.sv
`timescale 1ns/1ps

module testbench;
   reg         i_clk = 1'b0;
   reg         i_rst = 1'b1;
   reg         slow = 1'b0;
   reg         ps_v = 1'b0;
   reg         ps_w = 1'b0;
   reg  [31:0] ps_id = 32'h00000000;
   reg  [31:0] ps_wd = 32'h00000000;
   wire        rxv, rxc, rxr, txv, txc, txl, txr, ps_r, ps_a, ps_e;
   wire [7:0]  rxd, txd;
   wire [23:0] dest;
   wire [31:0] ps_rd;
   integer     mismatches = 0;
   integer     num_checks = 0;
   integer     cyc = 0;
   reg  [8:0]  ex[$];

   always #2.5 i_clk = ~i_clk;

   cfg_msg_endpoint dut (.i_clk(i_clk), .i_rst(i_rst), .i_rx_valid(rxv), .i_rx_ctrl(rxc),
      .i_rx_data(rxd), .o_rx_ready(rxr), .o_tx_valid(txv), .o_tx_ctrl(txc), .o_tx_data(txd),
      .o_tx_last(txl), .o_tx_dest(dest), .i_tx_ready(txr), .i_ps_valid(ps_v),
      .i_ps_write(ps_w), .i_ps_resid(ps_id), .i_ps_wdata(ps_wd), .o_ps_ready(ps_r),
      .o_ps_ack(ps_a), .o_ps_err(ps_e), .o_ps_rdata(ps_rd));
   req_model m (.i_clk(i_clk), .i_slow(slow), .i_rx_ready(rxr), .i_tx_valid(txv),
      .i_tx_ctrl(txc), .i_tx_data(txd), .i_tx_dest(dest), .o_valid(rxv), .o_ctrl(rxc),
      .o_data(rxd), .o_tx_ready(txr));

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task chk(input [63:0] seen, input [63:0] exp, input string what);
      num_checks = num_checks + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("MISMATCH %0s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches = mismatches + 1;
         finish_test;
      end
   end

   // the settle wait also proves that no stray tokens follow
   task reply(input string what);
      integer i;
      for (i = 0; i < 300 && m.got.size() < ex.size(); i = i + 1) @(posedge i_clk);
      repeat (20) @(posedge i_clk);
      chk(m.got.size(), ex.size(), {what, " length"});
      for (i = 0; i < ex.size(); i = i + 1) chk(m.got[i], ex[i], what);
      m.got.delete();
      ex.delete();
   endtask

   task ps(input w, input [31:0] rid, input [31:0] wd, input [31:0] erd, input ee);
      ps_v  <= 1'b1;
      ps_w  <= w;
      ps_id <= rid;
      ps_wd <= wd;
      do @(negedge i_clk); while (!ps_r);
      @(posedge i_clk);
      ps_v <= 1'b0;
      @(negedge i_clk);
      chk(ps_a, 1'b1, "status ack");
      chk(ps_e, ee, "status err");
      chk(ps_rd, erd, "status rdata");
      @(posedge i_clk);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task t_write_read;
      m.msg(8'hC0, 24'h123456, 16'h0005, 32'hA1B2C3D4, 9);
      ex = '{9'h103, 9'h101};
      reply("write ok");
      chk(m.dest_seen, 24'h123456, "write dest");
      slow <= 1'b1;
      m.msg(8'hC1, 24'h654321, 16'h0005, 32'h00000000, 5);
      ex = '{9'h103, 9'h0A1, 9'h0B2, 9'h0C3, 9'h0D4, 9'h101};
      reply("read ok");
      chk(m.dest_seen, 24'h654321, "read dest");
      slow <= 1'b0;
   endtask

   task t_noreply;
      m.msg(8'hC0, 24'h1234FF, 16'h0003, 32'h89ABCDEF, 9);
      reply("suppressed");
      ps(1'b0, 32'h0000030C, 32'h00000000, 32'h89ABCDEF, 1'b0);
      m.msg(8'hC1, 24'h0000FF, 16'h0003, 32'h00000000, 5);
      ex = '{9'h103, 9'h089, 9'h0AB, 9'h0CD, 9'h0EF, 9'h101};
      reply("read with ff id");
   endtask

   task t_fail;
      m.msg(8'hC0, 24'h0A0B0C, 16'h0009, 32'h11111111, 9);
      ex = '{9'h104, 9'h101};
      reply("write bad reg");
      m.msg(8'hC1, 24'h0A0B0C, 16'h0100, 32'h00000000, 5);
      ex = '{9'h104, 9'h101};
      reply("read bad reg");
      m.msg(8'hC1, 24'h0A0B0C, 16'h0000, 32'h00000000, 3);
      ex = '{9'h104, 9'h101};
      reply("read cut short");
      m.msg(8'hC5, 24'h0A0B0C, 16'h0000, 32'h00000000, 5);
      reply("unknown op dropped");
      m.msg(8'hC1, 24'h0A0B0C, 16'h0000, 32'h22222222, 9);
      ex = '{9'h104, 9'h101};
      reply("read too long");
      m.msg(8'hC0, 24'h0A0B0C, 16'h0001, 32'h33333333, 7);
      ex = '{9'h104, 9'h101};
      reply("write cut short");
      ps(1'b0, 32'h0000010C, 32'h00000000, 32'h00000000, 1'b0);
      ps(1'b0, 32'h0000090C, 32'h00000000, 32'h00000000, 1'b1);
   endtask

   task t_ps;
      ps(1'b1, 32'h0000070C, 32'h55AA33CC, 32'h00000000, 1'b0);
      ps(1'b1, 32'h0000070D, 32'h12345678, 32'h00000000, 1'b1);
      ps(1'b0, 32'h0000050C, 32'h00000000, 32'hA1B2C3D4, 1'b0);
      m.msg(8'hC1, 24'h000102, 16'h0007, 32'h00000000, 5);
      ex = '{9'h103, 9'h055, 9'h0AA, 9'h033, 9'h0CC, 9'h101};
      reply("read status word");
   endtask

   initial begin
      repeat (6) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      t_write_read;
      t_noreply;
      t_fail;
      t_ps;
      finish_test;
   end
endmodule // testbench

bind cfg_msg_endpoint cfg_msg_endpoint_assertions chk_i (
   .i_clk      (i_clk),
   .i_rst      (i_rst),
   .o_rx_ready (o_rx_ready),
   .o_tx_valid (o_tx_valid),
   .o_tx_ctrl  (o_tx_ctrl),
   .o_tx_data  (o_tx_data),
   .o_tx_last  (o_tx_last),
   .o_tx_dest  (o_tx_dest),
   .i_tx_ready (i_tx_ready),
   .i_ps_valid (i_ps_valid),
   .i_ps_write (i_ps_write),
   .i_ps_resid (i_ps_resid),
   .o_ps_ready (o_ps_ready),
   .o_ps_ack   (o_ps_ack),
   .o_ps_err   (o_ps_err),
   .o_ps_rdata (o_ps_rdata)
);
